// >>> hdl/i2c_remote_io_expander_slave.sv
// Purpose: two-wire slave with 8-bit quasi-bidirectional port and interrupt
// Assumes: linkClk oversamples the bus lines; rst is synchronous to core_clk
// Notes: bus logic on linkClk, port latch and interrupt on core_clk

`default_nettype none

module i2c_remote_io_expander_slave
	import io_expander_pkg::*;
#(
	// fixed upper address nibble; value arbitrary
	parameter logic [io_expander_pkg::ADDR_FIX_W-1:0] ADDR_FIXED = 4'h5
) (
	// core clock and reset
	input  wire logic                              core_clk,
	input  wire logic                              rst,
	// link sampling clock
	input  wire logic                              linkClk,
	// serial bus, open drain
	input  wire logic                              sclIn,
	input  wire logic                              sdaIn,
	output var  logic                              sdaOut,
	output var  logic                              sdaOe,
	// hardware address pins
	input  wire logic [io_expander_pkg::ADDR_PIN_W-1:0] addrPins,
	// quasi-bidirectional port
	input  wire logic [io_expander_pkg::PORT_W-1:0] portIn,
	output var  logic [io_expander_pkg::PORT_W-1:0] portOut,
	output var  logic [io_expander_pkg::PORT_W-1:0] portOe,
	// open-drain interrupt
	output var  logic                              intOut,
	output var  logic                              intOe
);

	import io_expander_pkg::*;

	// link domain signals
	logic              linkRst;
	logic              sclS;
	logic              sdaS;
	logic              sclOld_ff;
	logic              sdaOld_ff;
	logic [ADDR_PIN_W-1:0] addrS;
	logic [PORT_W-1:0] portInL;
	link_state_t       state_ff;
	logic [3:0]        bitCnt_ff;
	logic [PORT_W-1:0] shift_ff;
	logic              rdMode_ff;
	logic              masterAck_ff;
	logic              sdaOe_ff;
	logic [PORT_W-1:0] wrData_ff;
	logic              wrTgl_ff;
	logic              clrTgl_ff;
	logic              startSeen;
	logic              stopSeen;
	logic              sclRise;
	logic              sclFall;
	logic [6:0]        myAddr;

	// core domain signals
	logic              wrPulse;
	logic              clrPulse;
	logic [PORT_W-1:0] portInC;
	logic [PORT_W-1:0] portLatch_ff;
	logic [PORT_W-1:0] refVal_ff;
	logic              refValid_ff;
	logic              intAct_ff;
	logic              changeNow;

	sync_2ff #(.WIDTH(1)) u_rst_link (
		.clk     (linkClk),
		.asyncIn (rst),
		.syncOut (linkRst)
	);

	sync_2ff #(.WIDTH(2)) u_bus_sync (
		.clk     (linkClk),
		.asyncIn ({sclIn, sdaIn}),
		.syncOut ({sclS, sdaS})
	);

	sync_2ff #(.WIDTH(ADDR_PIN_W + PORT_W)) u_pin_sync_link (
		.clk     (linkClk),
		.asyncIn ({addrPins, portIn}),
		.syncOut ({addrS, portInL})
	);

	sync_2ff #(.WIDTH(PORT_W)) u_pin_sync_core (
		.clk     (core_clk),
		.asyncIn (portIn),
		.syncOut (portInC)
	);

	toggle_sync u_wr_xing (
		.dstClk   (core_clk),
		.dstRst   (rst),
		.tglIn    (wrTgl_ff),
		.pulseOut (wrPulse)
	);

	toggle_sync u_clr_xing (
		.dstClk   (core_clk),
		.dstRst   (rst),
		.tglIn    (clrTgl_ff),
		.pulseOut (clrPulse)
	);

	always_ff @(posedge linkClk)
	begin
		if (linkRst)
		begin
			sclOld_ff <= 1'b1;
			sdaOld_ff <= 1'b1;
		end
		else
		begin
			sclOld_ff <= sclS;
			sdaOld_ff <= sdaS;
		end
	end

	assign startSeen = bus_cond(sclS, sclOld_ff, sdaS, sdaOld_ff, 1'b0);
	assign stopSeen  = bus_cond(sclS, sclOld_ff, sdaS, sdaOld_ff, 1'b1);
	assign sclRise   = sclS & ~sclOld_ff;
	assign sclFall   = ~sclS & sclOld_ff;
	// hardware pins form the low address bits
	assign myAddr    = {ADDR_FIXED, addrS};

	// bus protocol: only samples the clock, never drives it
	// slave only
	always_ff @(posedge linkClk)
	begin
		if (linkRst)
		begin
			state_ff     <= LINK_IDLE;
			bitCnt_ff    <= 4'h0;
			shift_ff     <= ALL_ZERO;
			rdMode_ff    <= 1'b0;
			masterAck_ff <= 1'b0;
			sdaOe_ff     <= 1'b0;
		end
		else if (stopSeen)
		begin
			state_ff <= LINK_IDLE;
			sdaOe_ff <= 1'b0;
		end
		else if (startSeen)
		begin
			state_ff  <= LINK_ADDR;
			bitCnt_ff <= 4'h0;
			sdaOe_ff  <= 1'b0;
		end
		else
		begin
			case (state_ff)
				LINK_IDLE:
				begin
					sdaOe_ff <= 1'b0;
				end
				LINK_ADDR, LINK_WR:
				begin
					// sample on clock high, msb first
					if (sclRise)
					begin
						shift_ff  <= {shift_ff[PORT_W-2:0], sdaS};
						bitCnt_ff <= bitCnt_ff + 4'h1;
					end
					else if (sclFall && bitCnt_ff == BYTE_BITS)
					begin
						bitCnt_ff <= 4'h0;
						if (state_ff == LINK_WR)
						begin
							// acknowledge every byte, no byte limit
							sdaOe_ff <= 1'b1;
							state_ff <= LINK_ACK_WR;
						end
						// seven-bit compare, low bit selects direction
						else if (shift_ff[PORT_W-1:1] == myAddr)
						begin
							sdaOe_ff  <= 1'b1;
							rdMode_ff <= shift_ff[RW_BIT];
							state_ff  <= LINK_ACK_ADDR;
						end
						else
						begin
							state_ff <= LINK_IDLE;
						end
					end
				end
				LINK_ACK_ADDR:
				begin
					// ack held low until clock falls
					if (sclFall)
					begin
						bitCnt_ff <= 4'h0;
						if (rdMode_ff)
						begin
							shift_ff <= portInL;
							sdaOe_ff <= ~portInL[PORT_W-1];
							state_ff <= LINK_RD;
						end
						else
						begin
							sdaOe_ff <= 1'b0;
							state_ff <= LINK_WR;
						end
					end
				end
				LINK_ACK_WR:
				begin
					if (sclFall)
					begin
						sdaOe_ff <= 1'b0;
						state_ff <= LINK_WR;
					end
				end
				LINK_RD:
				begin
					if (sclRise)
					begin
						bitCnt_ff <= bitCnt_ff + 4'h1;
					end
					else if (sclFall && bitCnt_ff == BYTE_BITS)
					begin
						// transmitter releases data for ack slot
						sdaOe_ff  <= 1'b0;
						bitCnt_ff <= 4'h0;
						state_ff  <= LINK_RD_ACK;
					end
					// next bit changes only while clock low
					else if (sclFall)
					begin
						sdaOe_ff <= ~shift_ff[3'(BIT_MSB - bitCnt_ff[2:0])];
					end
				end
				LINK_RD_ACK:
				begin
					if (sclRise)
					begin
						masterAck_ff <= ~sdaS;
					end
					else if (sclFall)
					begin
						if (masterAck_ff)
						begin
							shift_ff <= portInL;
							sdaOe_ff <= ~portInL[PORT_W-1];
							state_ff <= LINK_RD;
						end
						else
						begin
							// no ack: stay released for master stop
							sdaOe_ff <= 1'b0;
							state_ff <= LINK_IDLE;
						end
					end
				end
				default:
				begin
					state_ff <= LINK_IDLE;
					sdaOe_ff <= 1'b0;
				end
			endcase
		end
	end

	// write byte and interrupt clear events toward the core
	always_ff @(posedge linkClk)
	begin
		if (linkRst)
		begin
			wrData_ff <= PORT_RESET;
			wrTgl_ff  <= 1'b0;
			clrTgl_ff <= 1'b0;
		end
		else
		begin
			// read clears at rising clock of address ack
			if (state_ff == LINK_ACK_ADDR && rdMode_ff && sclRise && !startSeen && !stopSeen)
			begin
				clrTgl_ff <= ~clrTgl_ff;
			end
			// byte only takes effect at its ack, falling clock
			if (state_ff == LINK_ACK_WR && sclFall && !startSeen && !stopSeen)
			begin
				wrData_ff <= shift_ff;
				wrTgl_ff  <= ~wrTgl_ff;
			end
		end
	end

	// bus output pins: data pulled low only
	always_ff @(posedge linkClk)
	begin
		if (linkRst)
		begin
			sdaOut <= 1'b0;
			sdaOe  <= 1'b0;
		end
		else
		begin
			sdaOut <= 1'b0;
			sdaOe  <= sdaOe_ff;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			portLatch_ff <= PORT_RESET;
		end
		else if (wrPulse)
		begin
			portLatch_ff <= wrData_ff;
		end
	end

	// latched zero pulls the pin low; one leaves it as weak-high input
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			portOut <= ALL_ZERO;
			portOe  <= ALL_ZERO;
		end
		else
		begin
			portOut <= ALL_ZERO;
			portOe  <= ~portLatch_ff;
		end
	end

	// change on input-mode bits against reference
	assign changeNow = refValid_ff && (((portInC ^ refVal_ff) & portLatch_ff) != ALL_ZERO);

	// reference value and interrupt state
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			refVal_ff   <= PORT_RESET;
			refValid_ff <= 1'b0;
			intAct_ff   <= 1'b0;
		end
		else if (!refValid_ff || clrPulse || wrPulse)
		begin
			refVal_ff   <= portInC;
			refValid_ff <= 1'b1;
			intAct_ff   <= 1'b0;
		end
		else
		begin
			// set on change, clear on return to original
			intAct_ff <= changeNow;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			intOut <= 1'b0;
			intOe  <= 1'b0;
		end
		else
		begin
			intOut <= 1'b0;
			intOe  <= intAct_ff;
		end
	end

	sequence s_addr_match;
		state_ff == LINK_ADDR && sclFall && bitCnt_ff == BYTE_BITS
			&& shift_ff[PORT_W-1:1] == myAddr && !startSeen && !stopSeen;
	endsequence

	sequence s_ack_driven;
		sdaOe_ff && state_ff == LINK_ACK_ADDR;
	endsequence

	a_start_seen: assert property (@(posedge linkClk) disable iff (linkRst)
		startSeen && !stopSeen |=> state_ff == LINK_ADDR && !sdaOe_ff)
		else $error("start not taken");

	a_stop_release: assert property (@(posedge linkClk) disable iff (linkRst)
		stopSeen |=> state_ff == LINK_IDLE && !sdaOe_ff ##2 !sdaOe)
		else $error("stop did not release bus");

	a_addr_ack: assert property (@(posedge linkClk) disable iff (linkRst)
		s_addr_match |=> s_ack_driven)
		else $error("own address not acknowledged");

	a_write_ack: assert property (@(posedge linkClk) disable iff (linkRst)
		state_ff == LINK_WR && sclFall && bitCnt_ff == BYTE_BITS && !startSeen && !stopSeen
		|=> sdaOe_ff && state_ff == LINK_ACK_WR)
		else $error("written byte not acknowledged");

	a_nack_release: assert property (@(posedge linkClk) disable iff (linkRst)
		state_ff == LINK_RD_ACK && !masterAck_ff && sclFall && !startSeen && !stopSeen
		|=> !sdaOe_ff && state_ff == LINK_IDLE)
		else $error("data not released after missing ack");

	a_msb_first: assert property (@(posedge linkClk) disable iff (linkRst)
		state_ff == LINK_ACK_ADDR && rdMode_ff && sclFall && !startSeen && !stopSeen
		|=> sdaOe_ff == !shift_ff[PORT_W-1])
		else $error("read byte not msb first");

	a_data_on_low: assert property (@(posedge linkClk) disable iff (linkRst)
		$rose(sdaOe_ff) |-> $past(sclFall))
		else $error("data pulled low outside clock low");

	a_write_latch: assert property (@(posedge core_clk) disable iff (rst)
		wrPulse |=> portLatch_ff == $past(wrData_ff) ##1 portOe == ~$past(wrData_ff, 2))
		else $error("port latch not updated");

	a_int_clear: assert property (@(posedge core_clk) disable iff (rst)
		clrPulse |=> !intAct_ff ##1 !intOe)
		else $error("interrupt not cleared by access");

	a_int_raise: assert property (@(posedge core_clk) disable iff (rst)
		changeNow && !clrPulse && !wrPulse |=> intAct_ff ##1 intOe)
		else $error("input change did not raise interrupt");

endmodule : i2c_remote_io_expander_slave

`default_nettype wire

// >>> hdl/io_expander_pkg.sv
// Purpose: shared constants for the two-wire I/O expander slave
// Assumes: link logic is oversampled on its own clock; core logic on core_clk
// Notes:
// Summary of operation
// - One data bit per clock pulse; data changes only while clock is low.
// - Idle bus: clock and data both released high.
// - Data falling while clock high is a start condition.
// - Data rising while clock high is a stop condition.
// - Any number of bytes accepted between start and stop.
// - Bytes are eight bits, most significant first, then one acknowledge slot.
// - Master clocks the acknowledge slot; the transmitter releases data then.
// - Addressed slave receiver acknowledges every received byte.
// - Acknowledger holds data low through the whole acknowledge clock high.
// - After a missing acknowledge the slave keeps data released high.
// - Slave works with fast and slow timing without configuration.
// - Expander is only a slave: never drives clock, start or stop.
// - One 8-bit quasi-bidirectional port with latched outputs.
// - Open-drain interrupt output flags new input data without bus traffic.
// - Address includes three hardware pins, up to eight devices per bus.
// - Interrupt asserts on any edge at a port input in input mode.
// - Interrupt clears on return to original value or read/write of this device.
// - Stop mid-write keeps byte from last acknowledge; partial byte discarded.

`default_nettype none

package io_expander_pkg;

	localparam int          PORT_W      = 8;
	localparam logic [3:0]  BYTE_BITS   = 4'h8;
	localparam logic [2:0]  BIT_MSB     = 3'h7;
	localparam logic [PORT_W-1:0] PORT_RESET = 8'hff;
	localparam logic [PORT_W-1:0] ALL_ZERO   = 8'h00;
	localparam int          ADDR_PIN_W  = 3;
	localparam int          ADDR_FIX_W  = 4;
	localparam int          RW_BIT      = 0;

	typedef enum logic [2:0] {
		LINK_IDLE,
		LINK_ADDR,
		LINK_ACK_ADDR,
		LINK_WR,
		LINK_ACK_WR,
		LINK_RD,
		LINK_RD_ACK
	} link_state_t;

	// bus condition: clock high on both samples, data moved in given direction
	function automatic logic bus_cond(input logic sclNow, input logic sclOld,
	                                  input logic sdaNow, input logic sdaOld,
	                                  input logic risingData);
		bus_cond = sclNow & sclOld & (sdaNow != sdaOld) & (sdaNow == risingData);
	endfunction : bus_cond

endpackage : io_expander_pkg

`default_nettype wire

// >>> hdl/sync_2ff.sv
// Purpose: two-flop level synchroniser
// Assumes: input is asynchronous to clk
// Notes: first stage is read only by second stage

`default_nettype none

module sync_2ff #(
	parameter int WIDTH = 1
) (
	// clock
	input  wire logic             clk,
	// data
	input  wire logic [WIDTH-1:0] asyncIn,
	output var  logic [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_ff;

	always_ff @(posedge clk)
	begin
		stage1_ff <= asyncIn;
		syncOut   <= stage1_ff;
	end

endmodule : sync_2ff

`default_nettype wire

// >>> hdl/toggle_sync.sv
// Purpose: carries an event, sent as a toggle, into the destination clock
// Assumes: source toggles no faster than every three destination cycles
// Notes: one-cycle pulse per toggle

`default_nettype none

module toggle_sync (
	// clock and reset
	input  wire logic dstClk,
	input  wire logic dstRst,
	// event
	input  wire logic tglIn,
	output var  logic pulseOut
);

	logic tglSync;
	logic tglOld_ff;

	sync_2ff #(.WIDTH(1)) u_sync (
		.clk     (dstClk),
		.asyncIn (tglIn),
		.syncOut (tglSync)
	);

	always_ff @(posedge dstClk)
	begin
		if (dstRst)
		begin
			tglOld_ff <= 1'b0;
			pulseOut  <= 1'b0;
		end
		else
		begin
			tglOld_ff <= tglSync;
			pulseOut  <= tglSync ^ tglOld_ff;
		end
	end

endmodule : toggle_sync

`default_nettype wire

// >>> tb/i2c_master_model.sv
// Purpose: behavioural two-wire bus master facing the expander
// Assumes: lines pulled up; clk is the core clock
// Notes: every bus phase lasts QUARTER clk cycles

`default_nettype none

module i2c_master_model #(
	parameter int QUARTER = 250
) (
	// timing
	input  wire logic clk,
	// bus, open drain
	input  wire logic sdaBus,
	output var  logic sclLow,
	output var  logic sdaLow
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		sclLow = 1'b0;
		sdaLow = 1'b0;
	end

	task automatic setLines(input logic scl, input logic sda);
		sclLow <= ~scl;
		sdaLow <= ~sda;
		repeat (QUARTER) @(posedge clk);
	endtask : setLines

	task automatic startCond();
		// clock stays still on an idle bus; only a restart lifts data first
		if (sclLow)
			setLines(1'b0, 1'b1);
		setLines(1'b1, 1'b1);
		setLines(1'b1, 1'b1);
		setLines(1'b1, 1'b0);
		setLines(1'b1, 1'b0);
		setLines(1'b0, 1'b0);
	endtask : startCond

	task automatic stopCond();
		setLines(1'b0, 1'b0);
		setLines(1'b1, 1'b0);
		setLines(1'b1, 1'b0);
		setLines(1'b1, 1'b1);
		setLines(1'b1, 1'b1);
	endtask : stopCond

	task automatic xferBit(input logic b, output logic r);
		setLines(1'b0, b);
		setLines(1'b1, b);
		r = sdaBus;
		setLines(1'b1, b);
		setLines(1'b0, b);
	endtask : xferBit

	// msb first, master clocks the acknowledge
	task automatic xferByte(input logic [7:0] d, input logic ackIn,
	                        output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			xferBit(d[i], r);
			q[i] = r;
		end
		xferBit(ackIn, ack);
	endtask : xferByte

endmodule : i2c_master_model

`default_nettype wire

// >>> tb/i2c_remote_io_expander_slave_tb_top.sv
// Purpose: self-checking bench for the two-wire I/O expander slave
// Assumes: 100 kHz master model, pulled-up bus and port lines
// Notes: expectations come from the address, data and pins driven

`default_nettype none

module i2c_remote_io_expander_slave_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import io_expander_pkg::*;

	localparam logic [3:0] FIX_NIBBLE = 4'ha;  // arbitrary
	localparam int         WATCHDOG   = 99000;

	logic              core_clk;
	logic              rst;
	logic              linkClk;
	logic              sclLow;
	logic              mSdaLow;
	logic              sclLine;
	logic              sdaLine;
	logic              dutSdaOe;
	logic              dutSdaOut;
	logic              dutIntOut;
	logic [PORT_W-1:0] dutPortOut;
	logic [2:0]        addrPins;
	logic [PORT_W-1:0] portExt;
	logic [PORT_W-1:0] portPins;
	logic [PORT_W-1:0] portOe;
	logic              intOe;
	logic [7:0]        wrVal;
	logic [7:0]        rdVal;
	logic [7:0]        flipMask;
	logic              ackBit;
	int                err_count = 0;
	int                total_checks = 0;

	assign sclLine  = ~sclLow;
	assign sdaLine  = ~(mSdaLow | dutSdaOe);
	assign portPins = portExt & ~portOe;

	i2c_remote_io_expander_slave #(
		.ADDR_FIXED (FIX_NIBBLE)
	) dut_u (
		.core_clk (core_clk),
		.rst      (rst),
		.linkClk  (linkClk),
		.sclIn    (sclLine),
		.sdaIn    (sdaLine),
		.sdaOut   (dutSdaOut),
		.sdaOe    (dutSdaOe),
		.addrPins (addrPins),
		.portIn   (portPins),
		.portOut  (dutPortOut),
		.portOe   (portOe),
		.intOut   (dutIntOut),
		.intOe    (intOe)
	);

	i2c_master_model mstr_u (
		.clk    (core_clk),
		.sdaBus (sdaLine),
		.sclLow (sclLow),
		.sdaLow (mSdaLow)
	);

	initial
	begin
		core_clk = 1'b0;
	end

	always #5 core_clk = ~core_clk;

	// offset keeps link edges off core edges
	initial
	begin
		linkClk = 1'b0;
		#1.3;
		forever #3 linkClk = ~linkClk;
	end

	function automatic logic [7:0] addrByte(input logic [2:0] pins, input logic rd);
		addrByte = {FIX_NIBBLE, pins, rd};
	endfunction : addrByte

	task automatic checkBit(input logic got, input logic exp, input string what);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: %s got %b want %b", $time, what, got, exp);
		end
	endtask : checkBit

	task automatic checkByte(input logic [7:0] got, input logic [7:0] exp, input string what);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : checkByte

	task automatic waitCycles(input int n);
		repeat (n) @(posedge core_clk);
	endtask : waitCycles

	task automatic sendByte(input logic [7:0] d, input logic expAck);
		logic [7:0] q;
		logic       ack;
		mstr_u.xferByte(d, 1'b1, q, ack);
		checkBit(~ack, expAck, "acknowledge");
	endtask : sendByte

	task automatic give_verdict();
		$display("checks %0d, errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	initial
	begin
		rst      = 1'b1;
		addrPins = 3'h0;
		portExt  = 8'hff;
		void'($urandom(32'h446f8260));
		waitCycles(10);
		rst      <= 1'b0;
		addrPins <= 3'($urandom());
		waitCycles(10);
		checkBit(dutSdaOe, 1'b0, "data line after reset");
		checkByte(portOe, 8'h00, "port after reset");
		checkBit(intOe, 1'b0, "interrupt after reset");
		// two-byte write, port follows each byte
		wrVal = 8'($urandom());
		mstr_u.startCond();
		sendByte(addrByte(addrPins, 1'b0), 1'b1);
		sendByte(wrVal, 1'b1);
		checkByte(portOe, ~wrVal, "port after first byte");
		sendByte(8'hff, 1'b1);
		mstr_u.stopCond();
		checkByte(portOe, 8'h00, "port after second byte");
		// read random pins, end without acknowledge
		portExt <= 8'($urandom());
		waitCycles(4);
		mstr_u.startCond();
		sendByte(addrByte(addrPins, 1'b1), 1'b1);
		mstr_u.xferByte(8'hff, 1'b0, rdVal, ackBit);
		checkByte(rdVal, portExt, "read data");
		mstr_u.xferByte(8'hff, 1'b1, rdVal, ackBit);
		checkByte(rdVal, portExt, "second read data");
		checkBit(ackBit, 1'b1, "slave released ack slot");
		checkBit(dutSdaOe, 1'b0, "data line after no acknowledge");
		mstr_u.stopCond();
		waitCycles(10);
		checkBit(intOe, 1'b0, "interrupt after read");
		// pin edge raises interrupt, foreign access leaves it
		flipMask = 8'h01 << 3'($urandom_range(7, 0));
		portExt  <= portExt ^ flipMask;
		waitCycles(10);
		checkBit(intOe, 1'b1, "interrupt on pin edge");
		mstr_u.startCond();
		sendByte(addrByte(addrPins ^ 3'h1, 1'b0), 1'b0);
		mstr_u.stopCond();
		checkBit(intOe, 1'b1, "interrupt on foreign access");
		portExt <= portExt ^ flipMask;
		waitCycles(10);
		checkBit(intOe, 1'b0, "interrupt on return");
		portExt <= portExt ^ flipMask;
		waitCycles(10);
		checkBit(intOe, 1'b1, "interrupt on second edge");
		// write clears interrupt, cut byte leaves port alone
		wrVal = 8'($urandom());
		mstr_u.startCond();
		sendByte(addrByte(addrPins, 1'b0), 1'b1);
		sendByte(wrVal, 1'b1);
		checkBit(intOe, 1'b0, "interrupt after write");
		for (int i = 7; i >= 4; i--)
			mstr_u.xferBit(~wrVal[i], ackBit);
		mstr_u.stopCond();
		waitCycles(10);
		checkByte(portOe, ~wrVal, "port after cut byte");
		checkBit(dutSdaOut, 1'b0, "data output value");
		checkBit(dutIntOut, 1'b0, "interrupt output value");
		checkByte(dutPortOut, 8'h00, "port output value");
		give_verdict();
	end

	initial
	begin
		repeat (WATCHDOG) @(posedge core_clk);
		err_count++;
		$display("wrong value at %0t: watchdog expired", $time);
		give_verdict();
	end

endmodule : i2c_remote_io_expander_slave_tb_top

`default_nettype wire
